// File: verilog/dpg_gpio.v
// Purpose: Six-bit port A and eight-bit port B with change detection, APB slave
// Assumes: presetn is the power-on reset, other_reset a synchronous other reset
// Notes: Zero wait state APB; unmapped addresses answer with pslverr
`timescale 1ns/1ps
`include "dpg_regs.vh"

// How it works
// - Port A direction one floats, zero drives
// - Port A read gives pins, write latch
// - Set and clear writes merge sampled pins into latch
// - Bit 4 open drain, others push-pull
// - Port A bit 4 feeds timer clock
// - Three-bit field picks analog port A pins
// - After power-on pins other than bit 4 analog, read zero
// - Direction still drives analog pins; software sets
// - Port A direction resets to all ones
// - Port A upper bits read zero
// - Port B eight pins with direction bits
// - Clearing option bit 7 enables pull-ups
// - Output pins lose their pull-up
// - Pull-ups off after power-on reset
// - Only inputs among bits 7..4 compared
// - Mismatch against last read or write sets flag
// - Persisting mismatch keeps setting the flag
// - Mismatch wakes the device from sleep
// - Bit 0 is external interrupt input
module dpg_gpio (
    input wire pclk,
    input wire presetn,
    input wire ce,
    input wire other_reset,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire [5:0] port_a_in,
    output wire [5:0] port_a_out,
    output wire [5:0] port_a_oe,
    output wire [5:0] analog_select,
    output wire timer_clock_in,
    input wire [7:0] port_b_in,
    output wire [7:0] port_b_out,
    output wire [7:0] port_b_oe,
    output wire [7:0] port_b_pullup_en,
    output wire external_interrupt_pin,
    output wire ext_int_schmitt_en,
    output wire port_change_flag,
    output wire wake_request
);

wire [`DPG_PA_W-1:0] pa_pins;
wire [`DPG_PB_W-1:0] pb_pins;
reg [`DPG_PA_W-1:0] pa_latch;
reg [`DPG_PA_W-1:0] port_a_direction;
reg [`DPG_PB_W-1:0] pb_latch;
reg [`DPG_PB_W-1:0] port_b_direction;
reg [`DPG_PCFG_W-1:0] pin_config;
reg [7:0] option_reg;
reg change_flag;
reg ext_int_enable;
reg [3:0] pb_compare;
reg [`DPG_PA_W-1:0] analog_mask;
reg [7:0] next_rdata;
reg mapped;
wire [`DPG_IDX_W-1:0] idx;
wire setup;
wire access;
wire wr;
wire rd;
wire [3:0] chg_pins;
wire [3:0] chg_inputs;
wire mismatch;
wire [`DPG_PA_W-1:0] pa_read;
wire [`DPG_PA_W-1:0] pa_wdata;
wire [`DPG_PB_W-1:0] pb_wdata;
wire pb_touched;

// Port B sync feeds the change compare, so glitches of one cycle never reach the flag
dpg_sync #(
    .W(`DPG_PB_W)
) u_sync_b (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .pin(port_b_in),
    .stable(pb_pins)
);

dpg_sync #(
    .W(`DPG_PA_W)
) u_sync_a (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .pin(port_a_in),
    .stable(pa_pins)
);

// Bus decode
assign idx = paddr[9:2];
assign setup = psel & ~penable;
assign access = psel & penable & ce;
assign wr = access & pwrite & mapped;
assign rd = access & ~pwrite & mapped;
assign pready = 1'b1;
assign pslverr = psel & penable & ~mapped;

always @* begin
    case (idx)
        `DPG_IDX_PA_DATA, `DPG_IDX_PB_DATA, `DPG_IDX_INTCTL,
        `DPG_IDX_OPTION, `DPG_IDX_PA_DIR, `DPG_IDX_PB_DIR,
        `DPG_IDX_ANACFG, `DPG_IDX_PA_SET, `DPG_IDX_PA_CLR,
        `DPG_IDX_PB_SET, `DPG_IDX_PB_CLR: begin
            mapped = 1'b1;
        end
        default: begin
            mapped = 1'b0;
        end
    endcase
end

// Analog pin selection from the pin-configuration field
always @* begin
    case (pin_config)
        `DPG_PCFG_ALL0: begin
            analog_mask = `DPG_ANA_ALL;
        end
        `DPG_PCFG_ALL1: begin
            analog_mask = `DPG_ANA_ALL;
        end
        `DPG_PCFG_LOW4: begin
            analog_mask = `DPG_ANA_LOW4;
        end
        `DPG_PCFG_THREE: begin
            analog_mask = `DPG_ANA_THREE;
        end
        `DPG_PCFG_TWO: begin
            analog_mask = `DPG_ANA_TWO;
        end
        `DPG_PCFG_ONE: begin
            analog_mask = `DPG_ANA_ONE;
        end
        default: begin
            analog_mask = `DPG_ANA_NONE;
        end
    endcase
end

assign analog_select = analog_mask;
// Analog pins read zero in the digital path
assign pa_read = pa_pins & ~analog_mask;

// Writes sample pins first, then modify; a full write replaces all bits
assign pa_wdata = (idx == `DPG_IDX_PA_SET) ? (pa_read | pwdata[`DPG_PA_W-1:0]) :
                  (idx == `DPG_IDX_PA_CLR) ? (pa_read & ~pwdata[`DPG_PA_W-1:0]) :
                  pwdata[`DPG_PA_W-1:0];
assign pb_wdata = (idx == `DPG_IDX_PB_SET) ? (pb_pins | pwdata[`DPG_PB_W-1:0]) :
                  (idx == `DPG_IDX_PB_CLR) ? (pb_pins & ~pwdata[`DPG_PB_W-1:0]) :
                  pwdata[`DPG_PB_W-1:0];

assign pb_touched = access & mapped &
                    ((idx == `DPG_IDX_PB_DATA) |
                     (pwrite & ((idx == `DPG_IDX_PB_SET) | (idx == `DPG_IDX_PB_CLR))));

// Read data
always @* begin
    next_rdata = 8'h00;
    case (idx)
        `DPG_IDX_PA_DATA: begin
            next_rdata = {2'b00, pa_read};
        end
        `DPG_IDX_PB_DATA: begin
            next_rdata = pb_pins;
        end
        `DPG_IDX_PA_DIR: begin
            next_rdata = {2'b00, port_a_direction};
        end
        `DPG_IDX_PB_DIR: begin
            next_rdata = port_b_direction;
        end
        `DPG_IDX_OPTION: begin
            next_rdata = option_reg;
        end
        `DPG_IDX_ANACFG: begin
            next_rdata = {5'b00000, pin_config};
        end
        `DPG_IDX_INTCTL: begin
            next_rdata[`DPG_INT_CHANGE] = change_flag;
            next_rdata[`DPG_INT_EXT_EN] = ext_int_enable;
        end
        default: begin
            next_rdata = 8'h00;
        end
    endcase
end

// Read data is captured in the setup cycle and held through the access
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        prdata <= 32'h00000000;
    end else if (ce && setup) begin
        prdata <= {24'h000000, next_rdata};
    end
end

// Configuration registers; other_reset restores them but not the latches
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        port_a_direction <= `DPG_PA_DIR_RST;
        port_b_direction <= `DPG_PB_DIR_RST;
        option_reg <= `DPG_OPTION_RST;
        pin_config <= `DPG_PCFG_RST;
        ext_int_enable <= 1'b0;
    end else if (ce) begin
        if (other_reset) begin
            port_a_direction <= `DPG_PA_DIR_RST;
            port_b_direction <= `DPG_PB_DIR_RST;
            option_reg <= `DPG_OPTION_RST;
            pin_config <= `DPG_PCFG_RST;
            ext_int_enable <= 1'b0;
        end else if (wr) begin
            case (idx)
                `DPG_IDX_PA_DIR: begin
                    port_a_direction <= pwdata[`DPG_PA_W-1:0];
                end
                `DPG_IDX_PB_DIR: begin
                    port_b_direction <= pwdata[`DPG_PB_W-1:0];
                end
                `DPG_IDX_OPTION: begin
                    option_reg <= pwdata[7:0];
                end
                `DPG_IDX_ANACFG: begin
                    pin_config <= pwdata[`DPG_PCFG_W-1:0];
                end
                `DPG_IDX_INTCTL: begin
                    ext_int_enable <= pwdata[`DPG_INT_EXT_EN];
                end
                default: begin
                    pin_config <= pin_config;
                end
            endcase
        end
    end
end

// Output latches keep their value over other_reset
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        pa_latch <= `DPG_PA_LAT_RST;
        pb_latch <= `DPG_PB_LAT_RST;
    end else if (ce && wr) begin
        if ((idx == `DPG_IDX_PA_DATA) || (idx == `DPG_IDX_PA_SET) ||
            (idx == `DPG_IDX_PA_CLR)) begin
            pa_latch <= pa_wdata;
        end
        if ((idx == `DPG_IDX_PB_DATA) || (idx == `DPG_IDX_PB_SET) ||
            (idx == `DPG_IDX_PB_CLR)) begin
            pb_latch <= pb_wdata;
        end
    end
end

// Change detection on the upper nibble
assign chg_pins = pb_pins[`DPG_PB_CHG_HI:`DPG_PB_CHG_LO];
assign chg_inputs = port_b_direction[`DPG_PB_CHG_HI:`DPG_PB_CHG_LO];
assign mismatch = |((chg_pins ^ pb_compare) & chg_inputs);

// Any read or write of port B takes a fresh reference, ending the mismatch
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        pb_compare <= `DPG_PB_CMP_RST;
    end else if (ce && pb_touched) begin
        // A read keeps the nibble it returned, so a change during the access is not lost
        pb_compare <= pwrite ? chg_pins : prdata[`DPG_PB_CHG_HI:`DPG_PB_CHG_LO];
    end
end

// A still-present mismatch sets the flag again, so set beats clear
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        change_flag <= 1'b0;
    end else if (ce) begin
        if (other_reset) begin
            change_flag <= 1'b0;
        end else if (mismatch) begin
            change_flag <= 1'b1;
        end else if (wr && (idx == `DPG_IDX_INTCTL)) begin
            change_flag <= pwdata[`DPG_INT_CHANGE];
        end
    end
end

assign port_change_flag = change_flag;
// Wake follows mismatch without ce, but the port B sample behind it only moves while ce is high
assign wake_request = mismatch;

// Port A drivers
genvar k;
generate
    for (k = 0; k < `DPG_PA_W; k = k + 1) begin : g_pa
        if (k == `DPG_PA_OD_BIT) begin : g_od
            // Open drain can only pull low
            assign port_a_out[k] = 1'b0;
            assign port_a_oe[k] = ~port_a_direction[k] & ~pa_latch[k];
        end else begin : g_pp
            assign port_a_out[k] = pa_latch[k];
            assign port_a_oe[k] = ~port_a_direction[k];
        end
    end
endgenerate

// Bit 4 is shared with the timer clock input, taken from the stable sample
assign timer_clock_in = pa_pins[`DPG_PA_OD_BIT];

// Port B drivers and pull-ups
assign port_b_out = pb_latch;
assign port_b_oe = ~port_b_direction;
assign port_b_pullup_en = {`DPG_PB_W{~option_reg[`DPG_OPT_PULLUP_N]}} &
                          port_b_direction;

// External interrupt input; the schmitt buffer is selected while it is enabled
assign external_interrupt_pin = pb_pins[`DPG_PB_EXT_BIT];
assign ext_int_schmitt_en = ext_int_enable;

endmodule // dpg_gpio

// File: verilog/dpg_regs.vh
// Purpose: Register indices, field positions and reset values of the dual port GPIO
// Assumes: APB byte address is four times the register index
// Notes: Definitions only
`ifndef DPG_REGS_VH
`define DPG_REGS_VH

`define DPG_IDX_W 8
`define DPG_IDX_PA_DATA 8'h05
`define DPG_IDX_PB_DATA 8'h06
`define DPG_IDX_INTCTL 8'h0B
`define DPG_IDX_OPTION 8'h81
`define DPG_IDX_PA_DIR 8'h85
`define DPG_IDX_PB_DIR 8'h86
`define DPG_IDX_ANACFG 8'h9F
`define DPG_IDX_PA_SET 8'h40
`define DPG_IDX_PA_CLR 8'h41
`define DPG_IDX_PB_SET 8'h42
`define DPG_IDX_PB_CLR 8'h43

`define DPG_PA_W 6
`define DPG_PB_W 8
`define DPG_PCFG_W 3

`define DPG_PA_DIR_RST 6'h3F
`define DPG_PB_DIR_RST 8'hFF
`define DPG_OPTION_RST 8'hFF
`define DPG_PCFG_RST 3'h0
`define DPG_PA_LAT_RST 6'h00
`define DPG_PB_LAT_RST 8'h00
`define DPG_PB_CMP_RST 4'h0

`define DPG_OPT_PULLUP_N 7
`define DPG_INT_CHANGE 0
`define DPG_INT_EXT_EN 4
`define DPG_PA_OD_BIT 4
`define DPG_PB_EXT_BIT 0
`define DPG_PB_CHG_HI 7
`define DPG_PB_CHG_LO 4

`define DPG_ANA_ALL 6'h2F
`define DPG_ANA_LOW4 6'h0F
`define DPG_ANA_THREE 6'h0B
`define DPG_ANA_TWO 6'h03
`define DPG_ANA_ONE 6'h01
`define DPG_ANA_NONE 6'h00
`define DPG_PCFG_ALL0 3'h0
`define DPG_PCFG_ALL1 3'h1
`define DPG_PCFG_LOW4 3'h2
`define DPG_PCFG_THREE 3'h3
`define DPG_PCFG_TWO 3'h4
`define DPG_PCFG_ONE 3'h5

`define DPG_SYNC_RST 1'b0

`endif

// File: verilog/dpg_sync.v
// Purpose: Three-stage pin synchroniser with agreement filter
// Assumes: Inputs are asynchronous to pclk
// Notes: The stable value moves only when stages two and three agree
`timescale 1ns/1ps
`include "dpg_regs.vh"

module dpg_sync #(
    parameter W = 8
) (
    input wire pclk,
    input wire presetn,
    input wire ce,
    input wire [W-1:0] pin,
    output wire [W-1:0] stable
);

genvar i;
generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
        reg s1;
        reg s2;
        reg s3;
        reg hold;
        always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                s1 <= `DPG_SYNC_RST;
                s2 <= `DPG_SYNC_RST;
                s3 <= `DPG_SYNC_RST;
                hold <= `DPG_SYNC_RST;
            end else if (ce) begin
                s1 <= pin[i];
                s2 <= s1;
                s3 <= s2;
                // Stage one is read only by stage two
                if (s2 == s3) begin
                    hold <= s3;
                end
            end
        end
        assign stable[i] = hold;
    end
endgenerate

endmodule // dpg_sync

// File: test/dpg_gpio_properties.sv
// Purpose: Port-level checks of the dual port GPIO
// Assumes: Bound to dpg_gpio, one clock domain
// Notes: Pin follows wait six quiet cycles, covering the synchroniser
`timescale 1ns/1ps
module dpg_props (
    input wire pclk,
    input wire presetn,
    input wire ce,
    input wire other_reset,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire pslverr,
    input wire [5:0] port_a_in,
    input wire [5:0] port_a_out,
    input wire [5:0] port_a_oe,
    input wire [5:0] analog_select,
    input wire timer_clock_in,
    input wire [7:0] port_b_in,
    input wire [7:0] port_b_oe,
    input wire [7:0] port_b_pullup_en,
    input wire external_interrupt_pin,
    input wire port_change_flag,
    input wire wake_request
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_od_low: assert property (port_a_out[4] == 1'b0) else $error("open drain pin driven high");
    a_pullup_off: assert property ((port_b_pullup_en & port_b_oe) == 8'h00) else $error("pull-up on output");
    a_flag_set: assert property (ce && wake_request && !other_reset |=> port_change_flag)
        else $error("change flag not set");
    a_reset_vals: assert property ($rose(presetn) |-> port_a_oe == 6'h00 &&
        port_b_pullup_en == 8'h00 && analog_select == 6'h2F) else $error("bad reset outputs");
    a_err_access: assert property (pslverr |-> psel && penable) else $error("error outside access");
    a_timer_follow: assert property ((ce && $stable(port_a_in[4]))[*6] |-> timer_clock_in == port_a_in[4])
        else $error("timer clock lost pin");
    a_ext_follow: assert property ((ce && $stable(port_b_in[0]))[*6] |-> external_interrupt_pin == port_b_in[0])
        else $error("interrupt pin lost");
    a_dir_write: assert property (!$stable(port_b_oe) |-> $past(ce && (psel && penable && pwrite || other_reset)))
        else $error("direction changed unasked");
endmodule // dpg_props

bind dpg_gpio dpg_props i_dpg_props (.pclk, .presetn, .ce, .other_reset, .psel, .penable, .pwrite, .pslverr,
    .port_a_in, .port_a_out, .port_a_oe, .analog_select, .timer_clock_in, .port_b_in, .port_b_oe,
    .port_b_pullup_en, .external_interrupt_pin, .port_change_flag, .wake_request);

// File: test/dpg_pins.sv
// Purpose: External circuitry on the port pins
// Assumes: ext_*e high where the board drives a pin
// Notes: A floating pin without pull-up toggles every cycle so stale levels never pass
`timescale 1ns/1ps
module dpg_pins (
    input wire pclk,
    input wire [5:0] port_a_out,
    input wire [5:0] port_a_oe,
    input wire [5:0] ext_a,
    input wire [5:0] ext_ae,
    input wire [7:0] port_b_out,
    input wire [7:0] port_b_oe,
    input wire [7:0] port_b_pullup_en,
    input wire [7:0] ext_b,
    input wire [7:0] ext_be,
    output logic [5:0] port_a_in,
    output logic [7:0] port_b_in
);
    logic t = 1'b0;
    always @(posedge pclk) t <= ~t;
    // Open drain bit only ever drives low
    assign port_a_in = port_a_oe & port_a_out | ~port_a_oe & (ext_ae & ext_a | ~ext_ae & {6{t}});
    assign port_b_in = port_b_oe & port_b_out | ~port_b_oe & (ext_be & ext_b | ~ext_be & (port_b_pullup_en | {8{t}}));
endmodule // dpg_pins

// File: test/tb_top.sv
// Purpose: Self-checking bench of the dual port GPIO
// Assumes: ce held high throughout
// Notes: Six cycles are allowed for pins to pass the synchroniser
`timescale 1ns/1ps
`include "dpg_regs.vh"
module tb_top;
    logic pclk = 1'b0, presetn = 1'b0, ce = 1'b1, other_reset = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, rd;
    wire [31:0] prdata;
    wire pready, pslverr, timer_clock_in, external_interrupt_pin, ext_int_schmitt_en, port_change_flag, wake_request;
    wire [5:0] port_a_in, port_a_out, port_a_oe, analog_select;
    wire [7:0] port_b_in, port_b_out, port_b_oe, port_b_pullup_en;
    logic [5:0] ext_a = 6'h00, ext_ae = 6'h3F;
    logic [7:0] ext_b = 8'h00, ext_be = 8'hFF;
    int fail_count = 0, n_checks = 0;
    localparam logic [5:0] ANA [0:7] = '{6'h2F, 6'h2F, 6'h0F, 6'h0B, 6'h03, 6'h01, 6'h00, 6'h00};
    dpg_gpio i_dpg_gpio (.pclk, .presetn, .ce, .other_reset, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .port_a_in, .port_a_out, .port_a_oe, .analog_select, .timer_clock_in,
        .port_b_in, .port_b_out, .port_b_oe, .port_b_pullup_en, .external_interrupt_pin,
        .ext_int_schmitt_en, .port_change_flag, .wake_request);
    dpg_pins i_dpg_pins (.pclk, .port_a_out, .port_a_oe, .ext_a, .ext_ae, .port_b_out, .port_b_oe,
        .port_b_pullup_en, .ext_b, .ext_be, .port_a_in, .port_b_in);
    initial forever #5 pclk = ~pclk;
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task wt(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask
    task apb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {24'h0, wd};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n == 50) begin
            fail_count++;
            summarize;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask
    task t_reset;
        ext_a <= 6'h3F;
        wt(6);
        apb(0, `DPG_IDX_PA_DIR, 8'h00); chk(rd, 32'h3F);
        apb(0, `DPG_IDX_ANACFG, 8'h00); chk(rd, 32'h0);
        apb(0, `DPG_IDX_PA_DATA, 8'h00); chk(rd, 32'h10);
        apb(0, `DPG_IDX_OPTION, 8'h00); chk(rd, 32'hFF);
        chk(port_b_pullup_en, 32'h0);
        apb(0, 8'h00, 8'h00); chk(err, 32'h1);
        chk(rd, 32'h0);
        ext_a <= 6'h00;
    endtask
    task t_port_a_pin_data;
        apb(1, `DPG_IDX_PA_DIR, 8'h00);
        for (int i = 0; i < 8; i++) begin
            apb(1, `DPG_IDX_ANACFG, i[7:0]); chk(analog_select, ANA[i]);
            chk(port_a_oe, 32'h3F);
        end
        apb(1, `DPG_IDX_ANACFG, 8'h06);
        apb(1, `DPG_IDX_PA_DATA, 8'h2B);
        wt(6); chk(port_a_out, 32'h2B);
        apb(0, `DPG_IDX_PA_DATA, 8'h00); chk(rd, 32'h2B);
        apb(1, `DPG_IDX_ANACFG, 8'h05);
        apb(0, `DPG_IDX_PA_DATA, 8'h00); chk(rd, 32'h2A);
        apb(1, `DPG_IDX_ANACFG, 8'h06);
        apb(1, `DPG_IDX_PA_DATA, 8'h10);
        ext_a <= 6'h10;
        wt(6); chk(port_a_oe, 32'h2F);
        chk(timer_clock_in, 32'h1);
        apb(0, `DPG_IDX_PA_DATA, 8'h00); chk(rd, 32'h10);
        apb(1, `DPG_IDX_PA_DIR, 8'h3F); chk(port_a_oe, 32'h0);
        ext_a <= 6'h21;
        apb(1, `DPG_IDX_PA_DATA, 8'h0C); chk(port_a_out, 32'h0C);
        wt(6);
        apb(0, `DPG_IDX_PA_DATA, 8'h00); chk(rd, 32'h21);
        apb(1, `DPG_IDX_PA_SET, 8'h02);
        apb(1, `DPG_IDX_PA_DIR, 8'h00); chk(port_a_out, 32'h23);
        apb(1, `DPG_IDX_PA_DIR, 8'h3F);
    endtask
    task t_port_b_pin_data;
        apb(1, `DPG_IDX_PB_DIR, 8'hF0); chk(port_b_oe, 32'h0F);
        apb(1, `DPG_IDX_PB_DATA, 8'h05); chk(port_b_out, 32'h05);
        apb(1, `DPG_IDX_OPTION, 8'h7F); chk(port_b_pullup_en, 32'hF0);
        ext_be <= 8'h7F;
        wt(6);
        apb(0, `DPG_IDX_PB_DATA, 8'h00); chk(rd, 32'h85);
        ext_be <= 8'hFF;
        wt(6);
        apb(0, `DPG_IDX_PB_DATA, 8'h00);
        apb(1, `DPG_IDX_OPTION, 8'hFF); chk(port_b_pullup_en, 32'h0);
    endtask
    task t_change;
        apb(1, `DPG_IDX_PB_DIR, 8'hD8);
        apb(1, `DPG_IDX_INTCTL, 8'h00); chk(port_change_flag, 32'h0);
        apb(1, `DPG_IDX_PB_DATA, 8'h25);
        wt(6); chk(wake_request, 32'h0);
        ext_b <= 8'h08;
        wt(6); chk(wake_request, 32'h0);
        ext_b <= 8'h48;
        wt(6); chk(wake_request, 32'h1);
        chk(port_change_flag, 32'h1);
        apb(1, `DPG_IDX_INTCTL, 8'h00); chk(port_change_flag, 32'h1);
        apb(0, `DPG_IDX_PB_DATA, 8'h00); chk(rd, 32'h6D);
        chk(wake_request, 32'h0);
        apb(1, `DPG_IDX_INTCTL, 8'h00); chk(port_change_flag, 32'h0);
    endtask
    task t_ext;
        apb(1, `DPG_IDX_INTCTL, 8'h10); chk(ext_int_schmitt_en, 32'h1);
        apb(1, `DPG_IDX_PB_DIR, 8'hFF);
        ext_b <= 8'h49;
        wt(6); chk(external_interrupt_pin, 32'h1);
        ext_b <= 8'h48;
        wt(6); chk(external_interrupt_pin, 32'h0);
    endtask
    task t_other;
        apb(1, `DPG_IDX_PA_DIR, 8'h00);
        @(posedge pclk);
        other_reset <= 1'b1;
        @(posedge pclk);
        other_reset <= 1'b0;
        apb(0, `DPG_IDX_PA_DIR, 8'h00); chk(rd, 32'h3F);
    endtask
    task summarize;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        t_port_a_pin_data;
        t_port_b_pin_data;
        t_change;
        t_ext;
        t_other;
        summarize;
    end
    // Whole run needs about two hundred cycles
    initial begin
        #100000;
        fail_count++;
        summarize;
    end
endmodule // tb_top
